// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.svh"
// ==========================================================
// Bench for the sub-mode block
module testbench;
  // Host bus and pins
  logic                  clk, rstn, ce_n, rw, rxd, rxc, txc, cts_n, dcd_n, dsr_n;
  logic [1:0]            addr;
  logic [7:0]            db_i, db_o, rd;
  logic                  db_oe, txd, dtr_n, rts_n, txr_n, rxr_n, tem_n;
  // Shifter side
  usp_pkg::usp_rx_char_t rx_char;
  usp_pkg::usp_tx_stat_t tx_stat;
  usp_pkg::usp_tx_ctl_t  tx_ctl;
  usp_pkg::usp_rx_ctl_t  rx_ctl;
  usp_pkg::usp_mode_t    mode;
  int                    n_mismatch, check_count;
  logic [7:0]            syn_tbl [3] = '{8'h16, 8'h17, 8'h10}; // Sync, sync, DLE
  logic [7:0]            dbl_tbl [3] = '{8'h16, 8'h17, 8'h16}; // All stripped
  usp_core uut (
    .clk(clk), .rstn(rstn), .ce_n(ce_n), .rw(rw), .addr(addr), .db_i(db_i),
    .db_o(db_o), .db_oe(db_oe), .rxd(rxd), .rxc(rxc), .txc(txc), .cts_n(cts_n),
    .dcd_n(dcd_n), .dsr_n(dsr_n), .txd(txd), .dtr_n(dtr_n), .rts_n(rts_n),
    .tx_holding_ready_n(txr_n), .rx_holding_ready_n(rxr_n),
    .tx_empty_or_line_change_n(tem_n), .rx_char(rx_char), .tx_stat(tx_stat),
    .tx_ctl(tx_ctl), .rx_ctl(rx_ctl), .mode(mode)
  );
  usp_shifter_model u_part (
    .clk(clk), .rstn(rstn), .tx_ctl(tx_ctl), .tx_stat(tx_stat), .rx_char(rx_char)
  );
  // ==========================================================
  // Clocks: 40 ns system, 320 ns link
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    txc = 1'b0;
    #7;
    forever #160 txc = ~txc;
  end
  initial begin
    rxc = 1'b1;
    #93;
    forever #160 rxc = ~rxc;
  end
  // ==========================================================
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Host access, 5 cycles on, 5 off
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    ce_n <= 1'b0;
    rw <= w;
    addr <= a;
    db_i <= d;
    repeat (5) @(posedge clk);
    rd = db_o;
    ce_n <= 1'b1;
    db_i <= ~d;
    repeat (5) @(posedge clk);
  endtask
  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  // Bounded wait for empty
  task automatic wait_tem;
    for (int i = 0; i < 200 && tem_n !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog, run needs < 5000 cycles
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    ce_n = 1'b1;
    rw = 1'b0;
    addr = 2'h0;
    db_i = 8'h00;
    rstn = 1'b0;
    rxd = 1'b1;
    cts_n = 1'b1;
    dcd_n = 1'b1;
    dsr_n = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values
    rdchk(`USP_A_CMD, 8'h00);
    chk({3'h0, dtr_n, rts_n, txr_n, rxr_n, tem_n}, 8'h1F);
    rdchk(`USP_A_STAT, 8'h00);
    // Async with parity, enable both
    acc(1'b1, `USP_A_MODE, 8'h51);
    acc(1'b1, `USP_A_MODE, 8'h00);
    rdchk(`USP_A_MODE, 8'h51);
    acc(1'b1, `USP_A_CMD, 8'h27);
    chk({5'h0, dtr_n, rts_n, txr_n}, 8'h00);
    rdchk(`USP_A_STAT, 8'h01);
    // Modem inputs drop
    dcd_n <= 1'b0;
    dsr_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({7'h0, tem_n}, 8'h00);
    rdchk(`USP_A_STAT, 8'hC5);
    rdchk(`USP_A_STAT, 8'hC1);
    // Transmit
    acc(1'b1, `USP_A_DATA, 8'hA5);
    rdchk(`USP_A_STAT, 8'hC0);
    wait_tem();
    rdchk(`USP_A_STAT, 8'hC5);
    chk(u_part.last_tx, 8'hA5);
    acc(1'b1, `USP_A_DATA, 8'h5A);
    rdchk(`USP_A_STAT, 8'hC0);
    wait_tem();
    // Receive, errors, reset-error
    u_part.send_char(8'h3C, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk({7'h0, rxr_n}, 8'h00);
    rdchk(`USP_A_STAT, 8'hC7);
    rdchk(`USP_A_DATA, 8'h3C);
    rdchk(`USP_A_STAT, 8'hC5);
    u_part.send_char(8'h61, 1'b1, 1'b1);
    u_part.send_char(8'h62, 1'b0, 1'b0);
    rdchk(`USP_A_STAT, 8'hFF);
    rdchk(`USP_A_DATA, 8'h62);
    acc(1'b1, `USP_A_CMD, 8'h37);
    rdchk(`USP_A_STAT, 8'hC5);
    rdchk(`USP_A_CMD, 8'h27);
    // Break in async format
    acc(1'b1, `USP_A_CMD, 8'h2F);
    chk({6'h0, tx_ctl.send_break, tx_ctl.send_dle}, 8'h02);
    rdchk(`USP_A_CMD, 8'h2F);
    // Single sync strip, DLE send
    acc(1'b1, `USP_A_MODE, 8'h80);
    acc(1'b1, `USP_A_MODE, 8'h00);
    foreach (syn_tbl[i]) acc(1'b1, `USP_A_STAT, syn_tbl[i]);
    acc(1'b1, `USP_A_CMD, 8'h6F);
    chk({6'h0, tx_ctl.send_break, tx_ctl.send_dle}, 8'h01);
    acc(1'b1, `USP_A_CMD, 8'h67);
    u_part.send_char(8'h16, 1'b0, 1'b0);
    rdchk(`USP_A_STAT, 8'hE5);
    rdchk(`USP_A_STAT, 8'hC5);
    u_part.send_char(8'h42, 1'b0, 1'b0);
    rdchk(`USP_A_DATA, 8'h42);
    // Double sync strip
    rdchk(`USP_A_CMD, 8'h67);
    acc(1'b1, `USP_A_MODE, 8'h00);
    acc(1'b1, `USP_A_MODE, 8'h00);
    foreach (dbl_tbl[i]) u_part.send_char(dbl_tbl[i], 1'b0, 1'b0);
    rdchk(`USP_A_STAT, 8'hE5);
    u_part.send_char(8'h16, 1'b0, 1'b0);
    rdchk(`USP_A_DATA, 8'h16);
    // Local loop
    acc(1'b1, `USP_A_CMD, 8'hA3);
    rxd <= 1'b0;
    repeat (5) @(posedge clk);
    chk({5'h0, dtr_n, rts_n, txd}, 8'h07);
    chk({5'h0, rx_ctl.rx_serial, tx_ctl.cts_n, rx_ctl.rx_enable}, 8'h05);
    // Remote loop
    acc(1'b1, `USP_A_CMD, 8'hE7);
    rxd <= 1'b1;
    u_part.send_char(8'h55, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk({5'h0, txr_n, rxr_n, tem_n}, 8'h07);
    repeat (80) @(posedge clk);
    chk(u_part.last_tx, 8'h55);
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> usp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.svh"
// ==========================================================
// Sub-mode control and status block of a serial controller
// Functional notes
// (R1) Echo: retransmit rx, tx-ready held, enable ignored
// (R2) Single sync strip: drop first sync chars
// (R3) Double sync strip: drop each sync pair
// (R4) Transparent strip: drop DLE and DLE-sync
// (R5) Stripping leaves DLE and sync detect intact
// (R6) Local loop: internal loops, outputs held high
// (R7) Local loop needs transmit enable; receive enable ignored
// (R8) Remote loop: echo, no host data, flags
// (R9) Modem control bits drive pins inverted
// (R10) Break bit: async break, sync DLE
// (R11) Tx ready valid only while transmitter enabled
// (R12) Tx ready set on enable unless loaded
// (R13) Rx ready on char, cleared read/disable
// (R14) Empty set on shifter idle, cleared load
// (R15) Line change sets flag, status read clears
// (R16) Parity/DLE flag, first of two DLEs
// (R17) Overrun on unread; errors clear disable/reset
// (R18) Async framing flag on missing stop bit
// (R19) Sync detect flag by sync mode
// (R20) Framing/sync flag clearing depends on mode
// (R21) Top status bits mirror inverted modem inputs
// (R22) Reset-error command is a one-shot
// (R23) Mode bits select transparency and sync count
module usp_core (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Host bus pins
  input  wire logic                  ce_n,
  input  wire logic                  rw,
  input  wire logic [1:0]            addr,
  input  wire logic [7:0]            db_i,
  output logic      [7:0]            db_o,
  output logic                       db_oe,
  // Serial and modem pins
  input  wire logic                  rxd,
  input  wire logic                  rxc,
  input  wire logic                  txc,
  input  wire logic                  cts_n,
  input  wire logic                  dcd_n,
  input  wire logic                  dsr_n,
  output logic                       txd,
  output logic                       dtr_n,
  output logic                       rts_n,
  output logic                       tx_holding_ready_n,
  output logic                       rx_holding_ready_n,
  output logic                       tx_empty_or_line_change_n,
  // Shifter side
  input  wire usp_pkg::usp_rx_char_t rx_char,
  input  wire usp_pkg::usp_tx_stat_t tx_stat,
  output usp_pkg::usp_tx_ctl_t       tx_ctl,
  output usp_pkg::usp_rx_ctl_t       rx_ctl,
  output usp_pkg::usp_mode_t         mode
);
  // ==========================================================
  // Pin synchronisation
  usp_pkg::usp_state_t s_r;    // Registered state
  usp_pkg::usp_state_t s_nxt;  // Next state
  logic [17:0]         pins_s; // Synchronised pins
  logic                ce_s;   // Chip enable, active low
  logic                rw_s;   // High for write
  logic [1:0]          a_s;    // Register select
  logic [7:0]          db_s;   // Write data
  logic                rxd_s;
  logic                rxc_s;
  logic                txc_s;
  logic                cts_s;
  logic                dcd_s;
  logic                dsr_s;

  // Every pin idles high, so reset the stages to ones
  usp_sync2 #(
    .WIDTH   (18),
    .RST_VAL (18'h3FFFF)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({ce_n, rw, addr, db_i, rxd, rxc, txc, cts_n, dcd_n, dsr_n}),
    .q    (pins_s)
  );
  assign {ce_s, rw_s, a_s, db_s, rxd_s, rxc_s, txc_s, cts_s, dcd_s, dsr_s} = pins_s;

  // ==========================================================
  // Mode decode
  logic [1:0] sub;      // Operating sub-mode field
  logic       sync_md;  // Synchronous format
  logic       echo;     // Async automatic echo
  logic       strip;    // Sync automatic stripping
  logic       lloop;    // Local loop back
  logic       rloop;    // Remote loop back
  logic       transp;   // Transparency selected
  logic       single;   // Single sync selected
  logic       par_en;   // Parity enabled
  logic       tx_en;    // Effective transmitter enable
  logic       rx_en;    // Effective receiver enable
  logic       dcd_e;    // Carrier detect after looping
  logic       dsr_e;    // Data set ready after looping
  logic       tx_rdy;   // Transmit-ready status bit
  logic       ec_bit;   // Empty/change status bit

  assign sub     = s_r.cmd[`USP_CMD_SUB_HI:`USP_CMD_SUB_LO];
  assign sync_md = (s_r.mr1[`USP_MR_FMT_HI:`USP_MR_FMT_LO] == `USP_FMT_SYNC);
  assign echo    = (sub == `USP_SUB_ECHO) & ~sync_md;
  assign strip   = (sub == `USP_SUB_ECHO) & sync_md;
  assign lloop   = (sub == `USP_SUB_LOCAL);
  assign rloop   = (sub == `USP_SUB_REMOTE);
  assign transp  = s_r.mr1[`USP_MR_TRANSP];  // see (R23)
  assign single  = s_r.mr1[`USP_MR_SYNCNT];  // see (R23)
  assign par_en  = s_r.mr1[`USP_MR_PAR_EN];
  // Echo and remote loop run the transmitter whatever its enable says
  assign tx_en   = s_r.cmd[`USP_CMD_TRANSMIT_ENABLE_BIT] | echo | rloop;  // see (R1) (R8)
  // Local loop runs the receiver whatever its enable says
  assign rx_en   = s_r.cmd[`USP_CMD_RECEIVE_ENABLE_BIT] | lloop;  // see (R7)
  // Local loop feeds terminal-ready back as carrier and hides DSR
  assign dcd_e   = lloop ? ~s_r.cmd[`USP_CMD_DTR] : dcd_s;  // see (R6)
  assign dsr_e   = lloop ? 1'b1 : dsr_s;  // see (R6)
  // Ready only while enabled, never in the echoing modes
  assign tx_rdy  = tx_en & ~s_r.thr_full & ~echo & ~rloop;  // see (R11) (R12)
  // Echo shows only the line-change part
  assign ec_bit  = (s_r.temt & ~echo) | s_r.dschg;  // see (R1) (R14)

  // ==========================================================
  // Host access and character decode
  logic       acc_end;   // Chip enable just released
  logic       wr_end;    // End of a write access
  logic       rd_end;    // End of a read access
  logic [7:0] c;         // Received character
  logic       rx_ev;     // Character accepted this cycle
  logic       is_sy1;
  logic       is_sy2;
  logic       is_dle;
  logic       strip_hit; // Character withheld from host
  logic       syn_det;   // Sync detect condition
  logic       dle_det;   // DLE detect condition
  logic [7:0] status;    // Status register image

  assign acc_end = ce_s & ~s_r.ce_q;
  assign wr_end  = acc_end & s_r.acc_rw;
  assign rd_end  = acc_end & ~s_r.acc_rw;
  assign c       = rx_char.data;
  assign rx_ev   = rx_char.valid & rx_en;
  assign is_sy1  = (c == s_r.sy1);
  assign is_sy2  = (c == s_r.sy2);
  assign is_dle  = (c == s_r.dle);
  assign status  = {~dsr_e, ~dcd_e, s_r.ferr, s_r.oe, s_r.perr, ec_bit, s_r.rx_rdy, tx_rdy};  // see (R21)

  // Decide which characters stripping withholds from the host
  always_comb begin
    strip_hit = 1'b0;
    if (strip) begin
      if (transp) begin
        strip_hit = s_r.pair_p ? is_sy1 : is_dle;  // see (R4)
      end else if (single) begin
        strip_hit = is_sy1;  // see (R2)
      end else begin
        // A second sync-one after a stripped one stays in the data
        strip_hit = s_r.pair_p ? (is_sy2 & ~is_sy1) : is_sy1;  // see (R3)
      end
    end
  end

  // Detect conditions are computed apart from stripping
  always_comb begin
    syn_det = 1'b0;
    if (transp & s_r.synced) begin
      syn_det = s_r.pair_p & is_sy1;  // see (R19)
    end else if (single) begin
      syn_det = is_sy1;  // see (R19)
    end else begin
      syn_det = s_r.prev_sy1 & is_sy2;  // see (R19)
    end
  end
  assign dle_det = sync_md & transp & ~par_en & is_dle & ~s_r.pair_p;  // see (R16) (R5)

  // ==========================================================
  // Next-state logic: clears first, sets afterwards
  always_comb begin
    s_nxt       = s_r;
    // Track the host strobe and hold the access fields
    s_nxt.ce_q  = ce_s;
    if (!ce_s) begin
      s_nxt.acc_a  = a_s;
      s_nxt.acc_rw = rw_s;
      s_nxt.acc_d  = db_s;
    end
    // Read data is registered while a read is under way
    s_nxt.db_oe = ~ce_s & ~rw_s;
    unique case (a_s)
      `USP_A_DATA: s_nxt.db_o = s_r.rxh;
      `USP_A_STAT: s_nxt.db_o = status;
      `USP_A_MODE: s_nxt.db_o = s_r.mr_ptr ? s_r.mr2 : s_r.mr1;
      `USP_A_CMD:  s_nxt.db_o = s_r.cmd;
    endcase
    // Receiver disabled: drop its flags and sync history
    if (!rx_en) begin
      s_nxt.rx_rdy    = 1'b0;  // see (R13)
      s_nxt.perr      = 1'b0;  // see (R17)
      s_nxt.oe        = 1'b0;  // see (R17)
      s_nxt.ferr      = 1'b0;  // see (R20)
      s_nxt.synced    = 1'b0;
      s_nxt.pair_p    = 1'b0;
      s_nxt.prev_sy1  = 1'b0;
    end
    // Side effects of reads take place at the end of the access
    if (rd_end) begin
      unique case (s_r.acc_a)
        `USP_A_DATA: s_nxt.rx_rdy = 1'b0;  // see (R13)
        `USP_A_STAT: begin
          s_nxt.dschg = 1'b0;  // see (R15)
          if (sync_md) begin
            s_nxt.ferr = 1'b0;  // see (R20)
          end
        end
        `USP_A_MODE: s_nxt.mr_ptr = ~s_r.mr_ptr;
        `USP_A_CMD: begin
          s_nxt.mr_ptr  = 1'b0;
          s_nxt.syn_ptr = 2'h0;
        end
      endcase
    end
    // Shifter took the holding register
    if (tx_stat.take) begin
      s_nxt.thr_full = 1'b0;
    end
    if (wr_end) begin
      unique case (s_r.acc_a)
        `USP_A_DATA: begin
          // Host link to the transmitter is cut while echoing
          if (!echo && !rloop) begin
            s_nxt.thr      = s_r.acc_d;
            s_nxt.thr_full = 1'b1;
            s_nxt.temt     = 1'b0;  // see (R14)
          end
        end
        `USP_A_STAT: begin
          unique case (s_r.syn_ptr)
            2'h0:    s_nxt.sy1 = s_r.acc_d;
            2'h1:    s_nxt.sy2 = s_r.acc_d;
            default: s_nxt.dle  = s_r.acc_d;
          endcase
          s_nxt.syn_ptr = (s_r.syn_ptr >= `USP_SYN_PTR_MAX) ? 2'h0 : s_r.syn_ptr + 2'h1;
        end
        `USP_A_MODE: begin
          if (s_r.mr_ptr) begin
            s_nxt.mr2 = s_r.acc_d;
          end else begin
            s_nxt.mr1 = s_r.acc_d;
          end
          s_nxt.mr_ptr = ~s_r.mr_ptr;
        end
        `USP_A_CMD: begin
          // The reset-error bit is acted on and never stored
          s_nxt.cmd = s_r.acc_d & ~(8'h01 << `USP_CMD_RSTERR);  // see (R22)
          if (s_r.acc_d[`USP_CMD_RSTERR]) begin
            s_nxt.perr = 1'b0;  // see (R17)
            s_nxt.oe = 1'b0;  // see (R17)
            if (!sync_md) begin
              s_nxt.ferr = 1'b0;  // see (R20)
            end
          end
        end
      endcase
    end
    // Character arrival; sets win over any clear above
    if (rx_ev) begin
      if (sync_md) begin
        s_nxt.pair_p    = ~s_r.pair_p & (transp ? is_dle : is_sy1);
        s_nxt.prev_sy1  = is_sy1;
        if (syn_det) begin
          s_nxt.ferr   = 1'b1;  // see (R19) (R5)
          s_nxt.synced = s_r.synced | transp;
        end
      end else if (rx_char.framing_err) begin
        s_nxt.ferr = 1'b1;  // see (R18)
      end
      if ((par_en & rx_char.parity_err) | dle_det) begin
        s_nxt.perr = 1'b1;  // see (R16)
      end
      // Remote loop keeps data away from the host
      if (!rloop && !strip_hit) begin
        if (s_nxt.rx_rdy) begin
          s_nxt.oe = 1'b1;  // see (R17)
        end
        s_nxt.rxh    = c;
        s_nxt.rx_rdy = 1'b1;  // see (R13)
      end
      // Echoing modes feed the character back to the transmitter
      if (echo || rloop) begin
        s_nxt.thr      = c;  // see (R1) (R8)
        s_nxt.thr_full = 1'b1;
        s_nxt.temt     = 1'b0;
      end
    end
    // Shifter ran dry, fill included
    if (tx_stat.done && !s_r.thr_full) begin
      s_nxt.temt = 1'b1;  // see (R14)
    end
    // Modem input change while either direction is enabled
    s_nxt.dcd_q = dcd_e;
    s_nxt.dsr_q = dsr_e;
    if ((tx_en | rx_en) && ((dcd_e != s_r.dcd_q) || (dsr_e != s_r.dsr_q))) begin
      s_nxt.dschg = 1'b1;  // see (R15)
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r       <= '0;
      s_r.ce_q  <= 1'b1;
      s_r.dcd_q <= 1'b1;
      s_r.dsr_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign db_o  = s_r.db_o;
  assign db_oe = s_r.db_oe;
  // Local loop holds the line outputs high
  assign txd   = lloop ? 1'b1 : tx_stat.serial;  // see (R6)
  assign dtr_n = lloop ? 1'b1 : ~s_r.cmd[`USP_CMD_DTR];  // see (R9) (R6)
  assign rts_n = lloop ? 1'b1 : ~s_r.cmd[`USP_CMD_RTS];  // see (R9) (R6)
  assign tx_holding_ready_n        = ~tx_rdy;  // see (R11) (R12)
  assign rx_holding_ready_n        = rloop | ~s_r.rx_rdy;  // see (R8) (R13)
  assign tx_empty_or_line_change_n = rloop | ~ec_bit;  // see (R8) (R15)

  // Transmitter controls; echoing modes clock it from the rx clock
  assign tx_ctl.thr_valid  = s_r.thr_full;
  assign tx_ctl.thr_data   = s_r.thr;
  assign tx_ctl.tx_enable  = tx_en;
  assign tx_ctl.send_break = ~sync_md & s_r.cmd[`USP_CMD_BRK];  // see (R10)
  assign tx_ctl.send_dle   = sync_md & s_r.cmd[`USP_CMD_BRK];  // see (R10)
  assign tx_ctl.tx_clk     = (echo | rloop) ? rxc_s : txc_s;  // see (R1) (R8)
  assign tx_ctl.cts_n      = lloop ? ~s_r.cmd[`USP_CMD_RTS] : cts_s;  // see (R6)
  // Receiver controls; local loop takes the tx bit and clock
  assign rx_ctl.rx_enable  = rx_en;
  assign rx_ctl.rx_serial  = lloop ? tx_stat.serial : rxd_s;  // see (R6)
  assign rx_ctl.rx_clk     = lloop ? txc_s : rxc_s;  // see (R6)
  assign mode.mr1  = s_r.mr1;
  assign mode.mr2  = s_r.mr2;
  assign mode.sy1  = s_r.sy1;
  assign mode.sy2  = s_r.sy2;
  assign mode.dle  = s_r.dle;
endmodule
`default_nettype wire

// >>> usp_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.svh"
// ==========================================================
// Port checks of the sub-mode block
module usp_core_sva (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // Host bus
  input wire logic                  ce_n,
  input wire logic                  rw,
  input wire logic                  db_oe,
  // Serial and ready pins
  input wire logic                  txd,
  input wire logic                  tx_holding_ready_n,
  input wire logic                  rx_holding_ready_n,
  input wire logic                  tx_empty_or_line_change_n,
  // Shifter side
  input wire usp_pkg::usp_rx_char_t rx_char,
  input wire usp_pkg::usp_tx_stat_t tx_stat,
  input wire usp_pkg::usp_tx_ctl_t  tx_ctl,
  input wire usp_pkg::usp_rx_ctl_t  rx_ctl,
  input wire usp_pkg::usp_mode_t    mode
);
  // One domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Bus driver
  bus_write_quiet_a: assert property ((!ce_n && rw) [*5] |-> !db_oe)
    else $error("bus driven on write");
  bus_release_a: assert property (ce_n [*5] |-> !db_oe)
    else $error("bus held after deselect");
  // ==========================================================
  // Serial source
  txd_source_a: assert property (txd || txd == tx_stat.serial)
    else $error("bad serial source");
  // Tx ready
  tx_ready_valid_a: assert property (!tx_holding_ready_n |-> tx_ctl.tx_enable && !tx_ctl.thr_valid)
    else $error("tx ready while busy");
  // Rx ready
  rx_ready_set_a: assert property (rx_char.valid && rx_ctl.rx_enable
    && rx_char.data != mode.sy1 && rx_char.data != mode.sy2 && rx_char.data != mode.dle
    |=> !rx_holding_ready_n || tx_holding_ready_n && tx_empty_or_line_change_n)
    else $error("rx ready not set");
  rx_ready_clear_a: assert property (!rx_ctl.rx_enable [*2] |-> rx_holding_ready_n)
    else $error("rx ready kept");
  // Empty flag
  tx_empty_set_a: assert property (tx_stat.done && !tx_ctl.thr_valid && tx_ctl.tx_enable
    |=> !tx_empty_or_line_change_n || tx_holding_ready_n)
    else $error("empty not set");
  // Break and DLE by format
  break_async_a: assert property (tx_ctl.send_break |-> mode.mr1[1:0] != `USP_FMT_SYNC && !tx_ctl.send_dle)
    else $error("break in sync");
  dle_sync_a: assert property (tx_ctl.send_dle |-> mode.mr1[1:0] == `USP_FMT_SYNC)
    else $error("DLE in async");
  // ==========================================================
  // Main scenarios reached
  rx_char_c: cover property (rx_char.valid && rx_ctl.rx_enable);
  tx_done_c: cover property (tx_stat.done);
  dle_send_c: cover property (tx_ctl.send_dle);
endmodule

bind usp_core usp_core_sva u_sva (
  .clk(clk), .rstn(rstn), .ce_n(ce_n), .rw(rw), .db_oe(db_oe), .txd(txd),
  .tx_holding_ready_n(tx_holding_ready_n), .rx_holding_ready_n(rx_holding_ready_n),
  .tx_empty_or_line_change_n(tx_empty_or_line_change_n), .rx_char(rx_char),
  .tx_stat(tx_stat), .tx_ctl(tx_ctl), .rx_ctl(rx_ctl), .mode(mode)
);
`default_nettype wire

// >>> usp_defines.svh
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH
// ==========================================================
// Register select codes on the two address pins
`define USP_A_DATA      2'h0
`define USP_A_STAT      2'h1
`define USP_A_MODE      2'h2
`define USP_A_CMD       2'h3
// ==========================================================
// Command register bit positions
`define USP_CMD_TRANSMIT_ENABLE_BIT    0
`define USP_CMD_DTR     1
`define USP_CMD_RECEIVE_ENABLE_BIT    2
`define USP_CMD_BRK     3
`define USP_CMD_RSTERR  4
`define USP_CMD_RTS     5
`define USP_CMD_SUB_HI  7
`define USP_CMD_SUB_LO  6
// Operating sub-mode field codes
`define USP_SUB_NORMAL  2'h0
`define USP_SUB_ECHO    2'h1
`define USP_SUB_LOCAL   2'h2
`define USP_SUB_REMOTE  2'h3
// ==========================================================
// Mode register 1 bit positions
`define USP_MR_FMT_HI   1
`define USP_MR_FMT_LO   0
`define USP_MR_PAR_EN   4
`define USP_MR_TRANSP   6
`define USP_MR_SYNCNT   7
`define USP_FMT_SYNC    2'h0
// ==========================================================
// Reset values and sequencer limits
`define USP_REG_RST     8'h00
`define USP_SYN_PTR_MAX 2'h2
`define USP_PIN_RST     8'hFF
`endif

// >>> usp_pkg.sv
package usp_pkg;
  // Character event from the receiver shifter
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_err;
    logic       framing_err;
  } usp_rx_char_t;
  // Transmitter shifter events
  typedef struct packed {
    logic take;
    logic done;
    logic serial;
  } usp_tx_stat_t;
  // Control towards the transmitter shifter
  typedef struct packed {
    logic       thr_valid;
    logic [7:0] thr_data;
    logic       tx_enable;
    logic       send_break;
    logic       send_dle;
    logic       tx_clk;
    logic       cts_n;
  } usp_tx_ctl_t;
  // Control towards the receiver shifter
  typedef struct packed {
    logic rx_enable;
    logic rx_serial;
    logic rx_clk;
  } usp_rx_ctl_t;
  // Mode and character registers
  typedef struct packed {
    logic [7:0] mr1;
    logic [7:0] mr2;
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [7:0] dle;
  } usp_mode_t;
  // Whole state of the control block
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] mr1;
    logic [7:0] mr2;
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [7:0] dle;
    logic [1:0] syn_ptr;
    logic       mr_ptr;
    logic [7:0] thr;
    logic       thr_full;
    logic [7:0] rxh;
    logic       rx_rdy;
    logic       temt;
    logic       dschg;
    logic       perr;
    logic       oe;
    logic       ferr;
    logic       synced;
    logic       pair_p;
    logic       prev_sy1;
    logic       ce_q;
    logic [1:0] acc_a;
    logic       acc_rw;
    logic [7:0] acc_d;
    logic       dcd_q;
    logic       dsr_q;
    logic [7:0] db_o;
    logic       db_oe;
  } usp_state_t;
endpackage

// >>> usp_shifter_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side shifter model
module usp_shifter_model #(
  parameter int TAKE_DLY  = 20, // Slow take, so a full holding register is seen
  parameter int SHIFT_DLY = 30  // Cycles spent on one character
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Control from the block
  input  wire usp_pkg::usp_tx_ctl_t tx_ctl,
  // Events towards the block
  output var usp_pkg::usp_tx_stat_t tx_stat,
  output var usp_pkg::usp_rx_char_t rx_char
);
  int         cnt;     // Cycle counter for take and shift
  logic       busy;    // A character is being shifted
  logic [7:0] last_tx; // Last taken, read by bench
  initial rx_char = '0;
  // ==========================================================
  // Transmit pulses
  always_ff @(posedge clk) begin
    tx_stat.take <= 1'b0;
    tx_stat.done <= 1'b0;
    if (!rstn) begin
      cnt <= 0;
      busy <= 1'b0;
      tx_stat.serial <= 1'b1;
    end else if (busy) begin
      // Toggle so a stale level shows
      cnt <= cnt + 1;
      tx_stat.serial <= ~tx_stat.serial;
      if (cnt == SHIFT_DLY) begin
        busy <= 1'b0;
        cnt <= 0;
        tx_stat.done <= 1'b1;
        tx_stat.serial <= 1'b1;
      end
    end else if (tx_ctl.thr_valid && tx_ctl.tx_enable) begin
      cnt <= cnt + 1;
      if (cnt == TAKE_DLY) begin
        busy <= 1'b1;
        cnt <= 0;
        tx_stat.take <= 1'b1;
        last_tx <= tx_ctl.thr_data;
      end
    end
  end
  // ==========================================================
  // Receive: one event, then inverted data
  task automatic send_char(input logic [7:0] d, input logic perr, input logic ferr);
    @(posedge clk);
    rx_char <= '{1'b1, d, perr, ferr};
    @(posedge clk);
    rx_char <= '{1'b0, ~d, 1'b0, 1'b0};
  endtask
endmodule
`default_nettype wire

// >>> usp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-stage synchroniser for pins outside the clock domain
module usp_sync2 #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;  // First stage, read only by q

  // Both stages reset to the idle pin level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire
